//--- design/sdram_in_cfg.svh
`ifndef SDRAM_IN_CFG_SVH
`define SDRAM_IN_CFG_SVH

// Command codes on {row strobe, column strobe, write strobe}
`define CMD_MODE_LOAD 3'h0
`define CMD_REFRESH 3'h1
`define CMD_ROW_CLOSE 3'h2
`define CMD_ACTIVATE 3'h3
`define CMD_WRITE 3'h4
`define CMD_READ 3'h5
`define CMD_BURST_STOP 3'h6
`define CMD_NOP 3'h7

// Field positions in addr_bus
`define PRE_FLAG_BIT 10
`define COL_MSB 7

// Burst length code in op-code bits 2:0
`define BL_MSB 2
`define BL_CODE_1 3'h0
`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define BL_1 4'h1
`define BL_2 4'h2
`define BL_4 4'h4
`define BL_8 4'h8

// Buffer depth
`define BUF_DEPTH 2'h2

`endif

//--- design/sdram_in_pkg.sv
package sdram_in_pkg;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_READ
    } phase_t;

    // One word on its way into the array
    typedef struct packed {
        logic [1:0] bank;
        logic [11:0] row;
        logic [7:0] col;
        logic [31:0] data;
        logic [3:0] byte_en;
    } wr_word_t;

    // Read request towards the array
    typedef struct packed {
        logic [1:0] bank;
        logic [11:0] row;
        logic [7:0] col;
    } rd_addr_t;

    // Whole state of the input stage
    typedef struct packed {
        logic cs_n;
        logic [2:0] cmd;
        logic [1:0] bank;
        logic [11:0] addr;
        logic [3:0] mask;
        logic [31:0] din;
        logic [3:0] mask_d1;
        logic [13:0] mode_op;
        logic [3:0][11:0] rows;
        logic [3:0] bank_open;
        phase_t phase;
        logic [1:0] burst_bank;
        logic [7:0] col;
        logic [3:0] left;
        logic auto_pre;
        logic rd_v;
        logic rd_v2;
        rd_addr_t rd_addr;
        logic [31:0] dq_out;
        logic [3:0] dq_oe;
        wr_word_t [1:0] buf_mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } state_t;

endpackage

//--- design/sdram_cmd_addr_mask_inputs.sv
`timescale 1ns/1ps
`include "sdram_in_cfg.svh"

// Overview of operation
// - Sample all command, address, mask inputs on rising edge
// - Low chip select enables decoder, high disables
// - Chip select high ignores commands, bursts continue
// - Byte mask keeps working while chip select high
// - Decode command from three strobes together
// - Masked write lanes leave array bytes unchanged
// - Masked read lanes go high-Z two cycles later
// - Mask bit n covers data byte n
// - All four mask bits behave identically
// - Bank select picks bank for commands
// - Mode load op-code from bank and address
// - Activate captures twelve-bit row for bank
// - Column from addr 7:0, flag sets auto-close
// - Row close: flag high all banks, else one
module sdram_cmd_addr_mask_inputs
    import sdram_in_pkg::*;
(
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Command and address pins
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [1:0] bank_select,
    input wire logic [11:0] addr_bus,
    input wire logic [3:0] byte_mask_lanes,
    // Data lines, split into in, out and per-lane enable
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic [3:0] data_oe,
    // Write words towards the array
    output logic wr_valid,
    output wr_word_t wr_word,
    input wire logic wr_ready,
    // Read requests towards the array
    output logic rd_req_valid,
    output rd_addr_t rd_req,
    input wire logic [31:0] rd_data,
    // Status
    output logic [3:0] bank_open,
    output logic [13:0] mode_op
);

    state_t s_reg;
    state_t s_next;

    // Decode scratch
    logic [3:0] blen;
    logic [1:0] b;
    logic [7:0] c;
    logic word_v;
    wr_word_t word;
    logic push;
    logic pop;
    logic room;

    // Burst length from the stored op-code; unknown codes run single
    always_comb begin
        case (s_reg.mode_op[`BL_MSB:0])
            `BL_CODE_1: blen = `BL_1;
            `BL_CODE_2: blen = `BL_2;
            `BL_CODE_4: blen = `BL_4;
            `BL_CODE_8: blen = `BL_8;
            default: blen = `BL_1;
        endcase
    end

    // Buffer has room for one more word
    // A command's word that meets a full buffer is lost; pace the writes
    assign room = (s_reg.cnt != `BUF_DEPTH);

    // Next state of the whole stage
    always_comb begin
        s_next = s_reg;
        b = s_reg.burst_bank;
        c = s_reg.col;
        word_v = 1'b0;
        word = '0;
        push = 1'b0;
        pop = 1'b0;
        if (!rst_b) begin
            s_next = '0;
            s_next.cs_n = 1'b1;
            s_next.cmd = `CMD_NOP;
        end else if (clk_en) begin
            // Pins are registered here; decode reads only these copies
            s_next.cs_n = chip_select_n;
            s_next.cmd = {row_strobe_n, column_strobe_n,
                write_strobe_n};
            s_next.bank = bank_select;
            s_next.addr = addr_bus;
            s_next.mask = byte_mask_lanes;
            s_next.din = data_in;
            // Second mask stage gives the two-cycle read turn-off
            s_next.mask_d1 = s_reg.mask;
            s_next.rd_v = 1'b0;
            s_next.rd_v2 = s_reg.rd_v;

            // Burst in progress runs on whatever chip select does
            if (s_reg.phase != PH_IDLE) begin
                if (s_reg.phase == PH_WRITE) begin
                    word_v = 1'b1;
                end else begin
                    s_next.rd_v = 1'b1;
                end
                // A full buffer stalls the write burst, not the read
                if (s_reg.phase == PH_READ || room) begin
                    s_next.col = c + 8'h01;
                    s_next.left = s_reg.left - 4'h1;
                    if (s_reg.left == 4'h1) begin
                        s_next.phase = PH_IDLE;
                        if (s_reg.auto_pre) begin
                            s_next.bank_open[b] = 1'b0;
                        end
                    end
                end
            end

            // Decoder only sees a command under a low chip select
            if (!s_reg.cs_n) begin
                case (s_reg.cmd)
                    `CMD_ACTIVATE: begin
                        s_next.rows[s_reg.bank] = s_reg.addr;
                        s_next.bank_open[s_reg.bank] = 1'b1;
                    end
                    `CMD_ROW_CLOSE: begin
                        if (s_reg.addr[`PRE_FLAG_BIT]) begin
                            s_next.bank_open = 4'h0;
                        end else begin
                            s_next.bank_open[s_reg.bank] = 1'b0;
                        end
                    end
                    `CMD_MODE_LOAD: begin
                        s_next.mode_op = {s_reg.bank, s_reg.addr};
                    end
                    `CMD_WRITE, `CMD_READ: begin
                        // A new access cuts off any running burst
                        b = s_reg.bank;
                        c = s_reg.addr[`COL_MSB:0];
                        s_next.burst_bank = b;
                        s_next.auto_pre = s_reg.addr[`PRE_FLAG_BIT];
                        s_next.col = c + 8'h01;
                        s_next.left = blen - 4'h1;
                        word_v = (s_reg.cmd == `CMD_WRITE);
                        s_next.rd_v = (s_reg.cmd == `CMD_READ);
                        if (blen == `BL_1) begin
                            s_next.phase = PH_IDLE;
                            if (s_reg.addr[`PRE_FLAG_BIT]) begin
                                s_next.bank_open[b] = 1'b0;
                            end
                        end else if (s_reg.cmd == `CMD_WRITE) begin
                            s_next.phase = PH_WRITE;
                        end else begin
                            s_next.phase = PH_READ;
                        end
                    end
                    `CMD_BURST_STOP: begin
                        s_next.phase = PH_IDLE;
                    end
                    default: begin
                    end
                endcase
            end

            // Read request address for this cycle
            if (s_next.rd_v) begin
                s_next.rd_addr.bank = b;
                s_next.rd_addr.row = s_reg.rows[b];
                s_next.rd_addr.col = c;
            end

            // Write word; a high mask bit drops its byte lane
            word.bank = b;
            word.row = s_reg.rows[b];
            word.col = c;
            word.data = s_reg.din;
            word.byte_en = ~s_reg.mask;
            push = word_v && room;
            pop = (s_reg.cnt != 2'h0) && wr_ready;
            if (push) begin
                s_next.buf_mem[s_reg.wp] = word;
                s_next.wp = ~s_reg.wp;
            end
            if (pop) begin
                s_next.rp = ~s_reg.rp;
            end
            s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};

            // Read data one cycle after request; lanes gated by mask
            if (s_reg.rd_v2) begin
                s_next.dq_out = rd_data;
            end
            s_next.dq_oe = {4{s_reg.rd_v2}} & ~s_reg.mask_d1;
        end
    end

    // Single state register
    // Reset lives in the next-state logic, so one flop bank serves all
    always_ff @(posedge mclk) begin
        s_reg <= s_next;
    end

    // Outputs
    assign data_out = s_reg.dq_out;
    assign data_oe = s_reg.dq_oe;
    assign wr_valid = (s_reg.cnt != 2'h0);
    assign wr_word = s_reg.buf_mem[s_reg.rp];
    assign rd_req_valid = s_reg.rd_v;
    assign rd_req = s_reg.rd_addr;
    assign bank_open = s_reg.bank_open;
    assign mode_op = s_reg.mode_op;

endmodule

//--- bench/array_model.sv
`timescale 1ns/1ps
module array_model
    import sdram_in_pkg::*;
(
    // Clock and test control
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic stall,
    // Write side
    input wire logic wr_valid,
    output logic wr_ready,
    // Read side
    input wire logic rd_req_valid,
    input wire rd_addr_t rd_req,
    output logic [31:0] rd_data,
    // Words taken so far
    output logic [3:0] pops
);
    // Stall on demand so that the buffer must fill
    assign wr_ready = !stall;
    // Data one cycle after the request, churns otherwise
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rd_data <= 32'h0;
            pops <= 4'h0;
        end else begin
            if (rd_req_valid) begin
                rd_data <= {10'h0, rd_req} ^ 32'ha5a5a5a5;
            end else begin
                rd_data <= ~rd_data;
            end
            if (wr_valid) begin
                pops <= pops + {3'h0, wr_ready};
            end
        end
    end
endmodule

//--- bench/sdram_cmd_addr_mask_inputs_properties.sv
`timescale 1ns/1ps
module sdram_inputs_chk (
    // Clock and pins
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [1:0] bank_select,
    input wire logic [11:0] addr_bus,
    input wire logic [3:0] byte_mask_lanes,
    // Outputs watched
    input wire logic [3:0] data_oe,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic rd_req_valid,
    input wire logic [3:0] bank_open,
    input wire logic [13:0] mode_op
);
    // Command seen only while selected
    wire sel = !chip_select_n && clk_en;
    wire [2:0] c = {row_strobe_n, column_strobe_n, write_strobe_n};
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_mode_code:
    assert property (sel && c == 3'h0 |-> ##2
        mode_op == $past({bank_select, addr_bus}, 2)) else $error("mode");
    chk_row_open:
    assert property (sel && c == 3'h3 |-> ##2 bank_open[$past(bank_select, 2)])
        else $error("open");
    chk_close_all:
    assert property (sel && c == 3'h2 && addr_bus[10] |-> ##2 bank_open == 4'h0)
        else $error("close");
    chk_read_req:
    assert property (sel && c == 3'h5 |-> ##2 rd_req_valid) else $error("rd");
    chk_cs_ignore:
    assert property (chip_select_n |-> ##2 $stable(mode_op)) else $error("cs");
    chk_oe_mask:
    assert property (rd_req_valid |-> ##2 data_oe == ~$past(byte_mask_lanes, 3))
        else $error("oe");
    chk_oe_cause:
    assert property (data_oe != 4'h0 |-> $past(rd_req_valid, 2)) else $error("d");
    chk_wr_push:
    assert property (sel && c == 3'h4 && !wr_valid |-> ##2 wr_valid)
        else $error("push");
    chk_wr_hold:
    assert property (wr_valid && !wr_ready |=> wr_valid) else $error("hold");
    cover property (sel && c == 3'h5);
    cover property (sel && c == 3'h4 && wr_valid);
    cover property (wr_valid && !wr_ready);
endmodule
bind sdram_cmd_addr_mask_inputs sdram_inputs_chk sdram_inputs_chk_i (.*);

//--- bench/sdram_cmd_addr_mask_inputs_tb.sv
`timescale 1ns/1ps
module sdram_cmd_addr_mask_inputs_tb;
    import sdram_in_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic csn = 1'b1;
    logic [2:0] c = 3'h7;
    logic [1:0] ba = 2'h0;
    logic [11:0] ad = 12'h000;
    logic [3:0] dm = 4'h0;
    logic [31:0] din = 32'h0;
    logic stall = 1'b0;
    logic [31:0] dout, rdd;
    logic [3:0] oe, bo, pops;
    logic wv, rv, wrdy;
    wr_word_t ww;
    rd_addr_t rq;
    logic [13:0] mo;
    int err_count = 0;
    int samples_checked = 0;
    sdram_cmd_addr_mask_inputs sdram_cmd_addr_mask_inputs_i (.mclk(mclk),
        .rst_b(rst_b), .clk_en(1'b1), .chip_select_n(csn),
        .row_strobe_n(c[2]), .column_strobe_n(c[1]), .write_strobe_n(c[0]),
        .bank_select(ba), .addr_bus(ad), .byte_mask_lanes(dm),
        .data_in(din), .data_out(dout), .data_oe(oe), .wr_valid(wv),
        .wr_word(ww), .wr_ready(wrdy), .rd_req_valid(rv), .rd_req(rq),
        .rd_data(rdd), .bank_open(bo), .mode_op(mo));
    array_model array_model_i (.mclk(mclk), .rst_b(rst_b), .stall(stall),
        .wr_valid(wv), .wr_ready(wrdy), .rd_req_valid(rv), .rd_req(rq),
        .rd_data(rdd), .pops(pops));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One command cycle, then deselect so stray codes never decode
    task cmd(input [2:0] k, input [1:0] b, input [11:0] a);
        @(posedge mclk) #1;
        {csn, c, ba, ad} = {1'b0, k, b, a};
        @(posedge mclk) #1;
        {csn, c} = 4'hf;
    endtask
    task wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task t_mode;
        cmd(3'h0, 2'h2, 12'h020);
        wt(1);
        chk(mo, 14'h2020);
        // Mode load code with select high must be ignored
        c = 3'h0;
        ad = 12'h003;
        wt(3);
        c = 3'h7;
        chk(mo, 14'h2020);
    endtask
    task t_bank;
        for (int i = 0; i < 4; i++) begin
            cmd(3'h3, i[1:0], 12'hfff);
        end
        wt(1);
        chk(bo, 4'hf);
        cmd(3'h2, 2'h1, 12'h000);
        wt(1);
        chk(bo, 4'hd);
        cmd(3'h2, 2'h1, 12'h400);
        wt(1);
        chk(bo, 4'h0);
        cmd(3'h3, 2'h2, 12'habc);
    endtask
    // Far side stalls: two words held, the third is dropped
    task t_write;
        stall = 1'b1;
        din = 32'h11223344;
        dm = 4'h5;
        cmd(3'h4, 2'h2, 12'h012);
        wt(1);
        chk(wv, 1);
        chk(ww, {2'h2, 12'habc, 8'h12, 32'h11223344, 4'ha});
        cmd(3'h4, 2'h2, 12'h013);
        cmd(3'h4, 2'h2, 12'h014);
        wt(2);
        stall = 1'b0;
        wt(4);
        chk(pops, 4'h2);
        chk(wv, 0);
    endtask
    task t_read;
        dm = 4'h3;
        cmd(3'h5, 2'h2, 12'h410);
        wt(1);
        chk(rv, 1);
        chk(rq, {2'h2, 12'habc, 8'h10});
        wt(2);
        chk(oe, 4'hc);
        chk(dout[31:16], 16'ha58f);
        wt(2);
        chk(oe, 4'h0);
        chk(bo, 4'h0);
    endtask
    // Bursts of four: read runs on under a high select, stop cuts it
    task t_burst;
        cmd(3'h0, 2'h0, 12'h002);
        wt(1);
        chk(mo, 14'h0002);
        cmd(3'h3, 2'h1, 12'h123);
        cmd(3'h5, 2'h1, 12'h0fe);
        for (int i = 0; i < 4; i++) begin
            wt(1);
            if (i == 0) begin
                c = 3'h0;
            end
            chk({rv, rq}, {1'b1, 2'h1, 12'h123, 8'hfe + i[7:0]});
        end
        c = 3'h7;
        wt(1);
        chk(rv, 0);
        chk(bo, 4'h2);
        chk(mo, 14'h0002);
        cmd(3'h5, 2'h1, 12'h000);
        cmd(3'h6, 2'h1, 12'h000);
        wt(2);
        chk(rv, 0);
        cmd(3'h4, 2'h1, 12'h020);
        wt(1);
        chk(ww, {2'h1, 12'h123, 8'h20, 32'h11223344, 4'hc});
        wt(5);
        chk(pops, 4'h6);
        chk(wv, 0);
    endtask
    task finish_test;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        forever #4 mclk = ~mclk;
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1 rst_b = 1'b1;
        t_mode;
        t_bank;
        t_write;
        t_read;
        t_burst;
        finish_test;
    end
    // Whole run takes about 80 cycles
    initial begin
        #20000;
        err_count++;
        finish_test;
    end
endmodule
